// ---- rtl/uart_rx_error_irq_wake.sv ----
// Serial port receiver with error flags, interrupt, address detect and pin wake-up
//
// The register offsets and strobed register access were left to the implementer.
`include "uart_rx_map.svh"
`timescale 1ns/1ns
`default_nettype none

// Function
// - Two-word receive buffer; third completed word with buffer full sets overrun.
// - Overrun keeps buffered words, drops shift register word, interrupts if enabled.
// - Overrun clears only on status access followed by data read.
// - Noisy frame still buffered; noise flag rises with receive-available, no own interrupt.
// - Noise flag clears when a data read removes its word; no status read needed.
// - Any stop bit decided low by the majority sets framing error, either of two stops.
// - Framing and parity flags stored with word; cleared on reset.
// - Parity mismatch against odd/even type sets parity flag when parity enabled.
// - Port interrupt is a low pulse over the five listed sources.
// - Separate enables per transmit source; receive sources share one enable.
// - Address detect enable gates interrupt on address word; no flag kept.
// - Status flags are read-only; writes and interrupt entry never change them.
// - With address detect, receive interrupt only when top data bit is one.
// - Without address detect, every receive-available raises the interrupt.
// - Port clock stopped pauses reception; it resumes when clock returns.
// - Idle or sleep leaves all port registers unchanged.
// - Falling pin edge with clock off and port, receiver, receive interrupt and wake enables set raises wake-up.
// - Data arriving during wake-up delay is ignored by receiver.
// - Wake interrupt needs global, group, channel enables; delivered after delay.
// - Word moved into buffer sets receive-available and interrupts if enabled.
// - Recovery runs at sixteen times baud; bit decided by three-sample majority.
module uart_rx_error_irq_wake (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_b,
  // Register port
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // Serial pin and port clock state
  input  wire logic       serial_pin,
  input  wire logic       port_clk_on,
  // Transmitter status and load
  input  wire logic       tx_empty_flag,
  input  wire logic       tx_idle_flag,
  output logic            tx_load,
  output logic      [8:0] tx_data,
  // System interrupt enables
  input  wire logic       global_irq_enable,
  input  wire logic       group_irq_enable,
  input  wire logic       channel_irq_enable,
  // Interrupt and wake outputs
  output logic            irq_req,
  output logic            irq_pulse_b,
  output logic            wake_req
);

  // Majority of three samples
  function automatic logic majority3(input logic a, input logic b, input logic c);
    majority3 = (a & b) | (a & c) | (b & c);
  endfunction : majority3

  uart_rx_pkg::reg_req_t  req;
  uart_rx_pkg::rx_state_t state_reg;
  uart_rx_pkg::rx_state_t state_next;
  uart_rx_pkg::rx_word_t  fifo_mem [0:1];
  uart_rx_pkg::rx_word_t  head;
  uart_rx_pkg::rx_word_t  new_word;

  logic [7:0] ctrl1_reg;
  logic [7:0] ctrl2_reg;
  logic [7:0] baud_divisor_reg;
  logic [7:0] reg_rdata_reg;
  logic [7:0] tick_cnt_reg;
  logic [3:0] sub_cnt_reg;
  logic [3:0] bit_cnt_reg;
  logic [8:0] shift_reg;
  logic [2:0] samp_reg;
  logic       noise_acc_reg;
  logic       parity_bit_reg;
  logic       framing_acc_reg;
  logic       pin_prev_reg;
  logic       rd_ptr_reg;
  logic       wr_ptr_reg;
  logic [1:0] count_reg;
  logic       overrun_flag;
  logic       status_seen_reg;
  logic       wake_pending_reg;
  logic [7:0] wake_cnt_reg;
  logic       wake_irq_reg;
  logic       wake_req_reg;
  logic       irq_prev_reg;
  logic       tx_load_reg;
  logic [8:0] tx_data_reg;

  // Register port bundle and decode
  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
  wire wr_ctrl1  = req.wr && req.addr == `OFS_CTRL1;
  wire wr_ctrl2  = req.wr && req.addr == `OFS_CTRL2;
  wire wr_baud   = req.wr && req.addr == `OFS_BAUD;
  wire wr_data   = req.wr && req.addr == `OFS_DATA;
  wire rd_status = req.rd && req.addr == `OFS_STATUS;
  wire rd_data   = req.rd && req.addr == `OFS_DATA;

  // Control fields
  wire port_enable        = ctrl1_reg[`C1_PORT_EN];
  wire nine_bit_select    = ctrl1_reg[`C1_NINE_BIT];
  wire parity_enable      = ctrl1_reg[`C1_PARITY_EN];
  wire parity_odd         = ctrl1_reg[`C1_PARITY_ODD];
  wire two_stop           = ctrl1_reg[`C1_TWO_STOP];
  wire tx_empty_ie        = ctrl2_reg[`C2_TX_EMPTY_IE];
  wire tx_idle_ie         = ctrl2_reg[`C2_TX_IDLE_IE];
  wire rx_irq_enable      = ctrl2_reg[`C2_RX_IE];
  wire receiver_enable    = ctrl2_reg[`C2_RX_EN];
  wire addr_detect_enable = ctrl2_reg[`C2_ADDR_DET];
  wire pin_wake_enable    = ctrl2_reg[`C2_WAKE_EN];

  // Receiver runs only with clock on and outside the wake-up delay
  wire wake_hold = wake_pending_reg;
  wire rx_run    = port_clk_on && port_enable && receiver_enable && !wake_hold;
  wire os_tick   = rx_run && (tick_cnt_reg == baud_divisor_reg);
  wire mid_done  = os_tick && (sub_cnt_reg == `SAMPLE_C);
  wire bit_end   = os_tick && (sub_cnt_reg == `OVERSAMPLE);
  // Decide on the two stored samples plus the one taken at this centre tick
  wire [2:0] samp_now = {samp_reg[1:0], serial_pin};
  wire bit_val   = majority3(samp_now[2], samp_now[1], samp_now[0]);
  wire bit_noisy = !(&samp_now) && (|samp_now);
  wire [3:0] nbits = nine_bit_select ? 4'h9 : 4'h8;
  wire [8:0] rx_word_data = nine_bit_select ? shift_reg : {1'b0, shift_reg[8:1]};

  // Word completion: after last stop bit centre
  wire last_stop = (state_reg == uart_rx_pkg::RX_STOP2) ||
                   (state_reg == uart_rx_pkg::RX_STOP1 && !two_stop);
  wire word_done = mid_done && last_stop;
  wire perr_calc = parity_enable && ((^rx_word_data ^ parity_bit_reg) != parity_odd);
  wire ferr_calc = framing_acc_reg || !bit_val;

  assign new_word = '{data: rx_word_data, framing: ferr_calc, parity: perr_calc,
                      noise: noise_acc_reg || bit_noisy};

  // Buffer occupancy
  wire fifo_pop  = rd_data && count_reg != 2'h0;
  wire fifo_push = word_done && (count_reg != 2'h2 || fifo_pop);
  wire ovr_set   = word_done && count_reg == 2'h2 && !fifo_pop;
  assign head    = fifo_mem[rd_ptr_reg];
  wire rx_avail_flag = count_reg != 2'h0;
  wire head_top  = nine_bit_select ? head.data[8] : head.data[7];

  // Status image; parity, noise and framing flags follow the head word, overrun does not
  wire [7:0] status_img = {rx_avail_flag && head.parity,
                           rx_avail_flag && head.noise,
                           rx_avail_flag && head.framing,
                           overrun_flag,
                           state_reg == uart_rx_pkg::RX_IDLE,
                           rx_avail_flag,
                           tx_idle_flag,
                           tx_empty_flag};

  // Read multiplexer
  wire [7:0] ctrl1_img = {ctrl1_reg[7:1], head.data[8]};
  wire [7:0] rd_mux = (req.addr == `OFS_STATUS) ? status_img :
                      (req.addr == `OFS_CTRL1)  ? ctrl1_img :
                      (req.addr == `OFS_CTRL2)  ? ctrl2_reg :
                      (req.addr == `OFS_DATA)   ? head.data[7:0] :
                      (req.addr == `OFS_BAUD)   ? baud_divisor_reg : 8'h00;

  // Receiver next state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      uart_rx_pkg::RX_IDLE:   if (rx_run && pin_prev_reg && !serial_pin) state_next = uart_rx_pkg::RX_START;
      uart_rx_pkg::RX_START:  if (mid_done) state_next = bit_val ? uart_rx_pkg::RX_IDLE :
                                                                 uart_rx_pkg::RX_DATA;
      uart_rx_pkg::RX_DATA:   if (mid_done && bit_cnt_reg == nbits - 4'h1)
                                state_next = parity_enable ? uart_rx_pkg::RX_PARITY :
                                                             uart_rx_pkg::RX_STOP1;
      uart_rx_pkg::RX_PARITY: if (mid_done) state_next = uart_rx_pkg::RX_STOP1;
      uart_rx_pkg::RX_STOP1:  if (mid_done) state_next = two_stop ? uart_rx_pkg::RX_STOP2 :
                                                                  uart_rx_pkg::RX_IDLE;
      uart_rx_pkg::RX_STOP2:  if (mid_done) state_next = uart_rx_pkg::RX_IDLE;
      default:                state_next = uart_rx_pkg::RX_IDLE;
    endcase
    if (wake_hold || !(port_enable && receiver_enable)) state_next = uart_rx_pkg::RX_IDLE;
  end

  // Interrupt sources; transmit sources have their own enables, receive sources share one
  wire src_tx_empty = tx_empty_ie && tx_empty_flag;
  wire src_tx_idle  = tx_idle_ie && tx_idle_flag;
  wire src_rx_avail = rx_irq_enable && rx_avail_flag &&
                      (!addr_detect_enable || head_top);
  wire src_overrun  = rx_irq_enable && overrun_flag;
  assign irq_req    = src_tx_empty || src_tx_idle || src_rx_avail ||
                      src_overrun || wake_irq_reg;
  assign irq_pulse_b = !(irq_req && !irq_prev_reg);

  // Wake-up detection while the port clock is off
  wire wake_event = !port_clk_on && pin_wake_enable && port_enable && receiver_enable &&
                    rx_irq_enable && pin_prev_reg && !serial_pin;
  wire irq_path_on = global_irq_enable && group_irq_enable && channel_irq_enable;

  // Control and divisor registers: only software writes change them
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ctrl1_reg        <= `CTRL1_RST;
      ctrl2_reg        <= `CTRL2_RST;
      baud_divisor_reg <= `BAUD_RST;
    end else begin
      if (wr_ctrl1) ctrl1_reg <= {req.wdata[7:1], 1'b0};
      if (wr_ctrl2) ctrl2_reg <= req.wdata;
      if (wr_baud)  baud_divisor_reg <= req.wdata;
    end
  end

  // Read data one cycle after the strobe
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) reg_rdata_reg <= 8'h00;
    else if (req.rd) reg_rdata_reg <= rd_mux;
    else reg_rdata_reg <= 8'h00;
  end
  assign reg_rdata = reg_rdata_reg;

  // Transmit load pulse; ninth bit taken from control register 1 bit 1
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      tx_load_reg <= 1'b0;
      tx_data_reg <= 9'h000;
    end else begin
      tx_load_reg <= wr_data;
      if (wr_data) tx_data_reg <= {ctrl1_reg[1], req.wdata};
    end
  end
  assign tx_load = tx_load_reg;
  assign tx_data = tx_data_reg;

  // Oversample tick divider and sub-bit counter; frozen while clock is off
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      tick_cnt_reg <= 8'h00;
      sub_cnt_reg  <= 4'h0;
    end else if (state_reg == uart_rx_pkg::RX_IDLE) begin
      tick_cnt_reg <= 8'h00;
      sub_cnt_reg  <= 4'h0;
    end else if (rx_run) begin
      tick_cnt_reg <= os_tick ? 8'h00 : tick_cnt_reg + 8'h01;
      if (os_tick) sub_cnt_reg <= sub_cnt_reg + 4'h1;
    end
  end

  // Three samples around bit centre
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) samp_reg <= 3'h0;
    else if (os_tick && (sub_cnt_reg == `SAMPLE_A || sub_cnt_reg == `SAMPLE_B ||
                         sub_cnt_reg == `SAMPLE_C))
      samp_reg <= {samp_reg[1:0], serial_pin};
  end

  // Frame sequencing, shifting and error accumulation
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_reg       <= uart_rx_pkg::RX_IDLE;
      bit_cnt_reg     <= 4'h0;
      shift_reg       <= 9'h000;
      noise_acc_reg   <= 1'b0;
      parity_bit_reg  <= 1'b0;
      framing_acc_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (state_reg == uart_rx_pkg::RX_IDLE) begin
        bit_cnt_reg     <= 4'h0;
        noise_acc_reg   <= 1'b0;
        framing_acc_reg <= 1'b0;
      end
      if (mid_done) begin
        noise_acc_reg <= noise_acc_reg || bit_noisy;
        case (state_reg)
          uart_rx_pkg::RX_DATA: begin
            shift_reg   <= {bit_val, shift_reg[8:1]};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end
          uart_rx_pkg::RX_PARITY: parity_bit_reg <= bit_val;
          uart_rx_pkg::RX_STOP1:  framing_acc_reg <= !bit_val;
          default: ;
        endcase
      end
    end
  end

  // Sub-bit alignment: restart centre count at each bit boundary
  // (sub counter wraps from 15 to 0 naturally; bit_end marks it)
  wire unused_bit_end = bit_end;

  // Two-word buffer with recorded flags
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      fifo_mem[0] <= '0;
      fifo_mem[1] <= '0;
      rd_ptr_reg  <= 1'b0;
      wr_ptr_reg  <= 1'b0;
      count_reg   <= 2'h0;
    end else begin
      if (fifo_push) begin
        fifo_mem[wr_ptr_reg] <= new_word;
        wr_ptr_reg <= !wr_ptr_reg;
      end
      if (fifo_pop) rd_ptr_reg <= !rd_ptr_reg;
      count_reg <= count_reg + {1'b0, fifo_push} - {1'b0, fifo_pop};
    end
  end

  // Overrun flag and status-then-data clear sequence; set wins over clear
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      overrun_flag    <= 1'b0;
      status_seen_reg <= 1'b0;
    end else begin
      if (rd_status) status_seen_reg <= 1'b1;
      else if (rd_data) status_seen_reg <= 1'b0;
      if (ovr_set) overrun_flag <= 1'b1;
      else if (rd_data && status_seen_reg) overrun_flag <= 1'b0;
    end
  end

  // Pin history, wake-up delay and wake interrupt
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pin_prev_reg     <= 1'b1;
      wake_pending_reg <= 1'b0;
      wake_cnt_reg     <= 8'h00;
      wake_irq_reg     <= 1'b0;
      wake_req_reg     <= 1'b0;
      irq_prev_reg     <= 1'b0;
    end else begin
      pin_prev_reg <= serial_pin;
      irq_prev_reg <= irq_req;
      wake_req_reg <= wake_event;
      wake_irq_reg <= 1'b0;
      if (wake_event) begin
        wake_pending_reg <= 1'b1;
        wake_cnt_reg     <= 8'h00;
      end else if (wake_pending_reg && port_clk_on) begin
        wake_cnt_reg <= wake_cnt_reg + 8'h01;
        if (wake_cnt_reg == `WAKE_DELAY_CYCLES - 8'h01) begin
          wake_pending_reg <= 1'b0;
          wake_irq_reg     <= irq_path_on;
        end
      end
    end
  end
  assign wake_req = wake_req_reg;

endmodule : uart_rx_error_irq_wake

`default_nettype wire

// ---- shared/uart_rx_map.svh ----
// Offsets, field positions, reset values and counts of the receive/interrupt block
`ifndef UART_RX_MAP_SVH
`define UART_RX_MAP_SVH

// Register offsets on the plain register port
`define OFS_STATUS        3'h0
`define OFS_CTRL1         3'h1
`define OFS_CTRL2         3'h2
`define OFS_DATA          3'h3
`define OFS_BAUD          3'h4

// Status register bit positions
`define ST_PARITY         7
`define ST_NOISE          6
`define ST_FRAMING        5
`define ST_OVERRUN        4
`define ST_RX_IDLE        3
`define ST_RX_AVAIL       2
`define ST_TX_IDLE        1
`define ST_TX_EMPTY       0

// Control register 1 bit positions
`define C1_PORT_EN        7
`define C1_NINE_BIT       6
`define C1_PARITY_EN      5
`define C1_PARITY_ODD     4
`define C1_TWO_STOP       3
`define C1_RX_BIT8        0

// Control register 2 bit positions
`define C2_TX_EMPTY_IE    7
`define C2_TX_IDLE_IE     6
`define C2_RX_IE          5
`define C2_RX_EN          4
`define C2_ADDR_DET       3
`define C2_WAKE_EN        2

// Reset values
`define CTRL1_RST         8'h00
`define CTRL2_RST         8'h00
`define BAUD_RST          8'h00

// Oversampling and majority sample points
`define OVERSAMPLE        4'hf
`define SAMPLE_A          4'h7
`define SAMPLE_B          4'h8
`define SAMPLE_C          4'h9

// Clock cycles between wake-up and resumed operation
`define WAKE_DELAY_CYCLES 8'h10

`endif

// ---- shared/uart_rx_pkg.sv ----
// Types shared by the receive/interrupt block
package uart_rx_pkg;

  // Receiver sequencing
  typedef enum logic [2:0] {
    RX_IDLE   = 3'b000,
    RX_START  = 3'b001,
    RX_DATA   = 3'b010,
    RX_PARITY = 3'b011,
    RX_STOP1  = 3'b100,
    RX_STOP2  = 3'b101
  } rx_state_t;

  // One buffered word with the error flags recorded beside it
  typedef struct packed {
    logic [8:0] data;
    logic       framing;
    logic       parity;
    logic       noise;
  } rx_word_t;

  // Register port request
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

endpackage : uart_rx_pkg

// ---- bench/serial_source.sv ----
// Remote serial transmitter model driving the receive pin
`timescale 1ns/1ns
`default_nettype none
module serial_source (
  // Clock
  input  wire logic clk_sys,
  // Line
  output logic      serial_pin
);
  // Clocks per bit with baud divisor 0
  int unsigned bit_clks = 16;

  // Line idles high between frames
  initial serial_pin = 1'b1;

  // One bit time, with an optional one-clock low spike at sub-tick 9
  task automatic put_bit(input logic b, input logic spike);
    for (int i = 0; i < bit_clks; i++) begin
      @(posedge clk_sys);
      serial_pin <= (spike && i == 9) ? 1'b0 : b;
    end
  endtask : put_bit

  // Start bit, LSB-first data, optional parity, stop bits, one idle bit
  task automatic send(input logic [8:0] d, input int nb, input logic pe, input logic pb,
                      input int ns, input logic [1:0] st, input logic spike);
    put_bit(1'b0, 1'b0);
    for (int k = 0; k < nb; k++) put_bit(d[k], spike && k == 2);
    if (pe) put_bit(pb, 1'b0);
    for (int k = 0; k < ns; k++) put_bit(st[k], 1'b0);
    put_bit(1'b1, 1'b0);
  endtask : send

  // Set the line to a level at the next clock; it stays there until driven again
  task automatic drive(input logic v);
    @(posedge clk_sys);
    serial_pin <= v;
  endtask : drive
endmodule : serial_source
`default_nettype wire

// ---- bench/uart_rx_monitor.sv ----
// Port-level checker for the receive/interrupt block
`include "uart_rx_map.svh"
`timescale 1ns/1ns
`default_nettype none
module uart_rx_monitor (
  // Clock and reset
  input wire logic       clk_sys,
  input wire logic       rst_b,
  // Register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // Power and transmitter state
  input wire logic       port_clk_on,
  input wire logic       tx_empty_flag,
  input wire logic       tx_idle_flag,
  input wire logic       tx_load,
  // Interrupt and wake
  input wire logic       irq_req,
  input wire logic       irq_pulse_b,
  input wire logic       wake_req
);
  logic [7:0] c1_reg;
  logic [7:0] c2_reg;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  // Shadow copies of the control registers, tracked from port writes
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      c1_reg <= `CTRL1_RST;
      c2_reg <= `CTRL2_RST;
    end else begin
      if (reg_wr && reg_addr == `OFS_CTRL1) c1_reg <= reg_wdata;
      if (reg_wr && reg_addr == `OFS_CTRL2) c2_reg <= reg_wdata;
    end
  end

  pulse_on_rise_a: assert property (irq_pulse_b == !(irq_req && !$past(irq_req)))
    else $error("irq pulse does not match request rise");
  pulse_one_cycle_a: assert property (!irq_pulse_b |=> irq_pulse_b)
    else $error("irq pulse longer than one cycle");
  empty_enable_a: assert property (c2_reg[`C2_TX_EMPTY_IE] && tx_empty_flag |-> irq_req)
    else $error("tx empty source lost");
  idle_enable_a: assert property (c2_reg[`C2_TX_IDLE_IE] && tx_idle_flag |-> irq_req)
    else $error("tx idle source lost");
  request_sources_a: assert property (irq_req |-> c2_reg[`C2_RX_IE] ||
    (c2_reg[`C2_TX_EMPTY_IE] && tx_empty_flag) || (c2_reg[`C2_TX_IDLE_IE] && tx_idle_flag))
    else $error("irq without enabled source");
  wake_qualified_a: assert property (wake_req |-> !$past(port_clk_on) &&
    c1_reg[`C1_PORT_EN] && c2_reg[`C2_RX_EN] && c2_reg[`C2_WAKE_EN] && c2_reg[`C2_RX_IE])
    else $error("wake without qualification");
  ctrl2_hold_a: assert property (reg_rd && reg_addr == `OFS_CTRL2 |=> reg_rdata == c2_reg)
    else $error("ctrl2 readback differs");
  ctrl1_hold_a: assert property (reg_rd && reg_addr == `OFS_CTRL1 |=>
    reg_rdata[7:1] == c1_reg[7:1])
    else $error("ctrl1 readback differs");

  // Main scenarios reached
  cover property (wake_req);
  cover property (!irq_pulse_b);
  cover property (tx_load);
endmodule : uart_rx_monitor

bind uart_rx_error_irq_wake uart_rx_monitor uart_rx_monitor_inst (.clk_sys(clk_sys),
  .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .port_clk_on(port_clk_on),
  .tx_empty_flag(tx_empty_flag), .tx_idle_flag(tx_idle_flag), .tx_load(tx_load),
  .irq_req(irq_req), .irq_pulse_b(irq_pulse_b), .wake_req(wake_req));
`default_nettype wire

// ---- bench/uart_rx_error_irq_wake_bench.sv ----
// Self-checking bench for the receive/interrupt block
`include "uart_rx_map.svh"
`timescale 1ns/1ns
`default_nettype none
module uart_rx_error_irq_wake_bench;
  logic       clk_sys = 1'b0;
  logic       rst_b = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic       port_clk_on = 1'b1;
  logic       tx_empty_flag = 1'b0;
  logic       tx_idle_flag = 1'b0;
  logic       group_irq_enable = 1'b1;
  wire logic [7:0] reg_rdata;
  wire logic [8:0] tx_data;
  wire logic  serial_pin;
  wire logic  tx_load;
  wire logic  irq_req;
  wire logic  irq_pulse_b;
  wire logic  wake_req;
  int         error_cnt = 0;
  int         samples_checked = 0;
  int         cyc = 0;
  int         n;
  logic [7:0] rv;
  logic [8:0] w;
  // Error rows: ctrl1, data, stop bits, expected flags {parity,noise,framing,overrun}
  logic [7:0] row_c1 [5] = '{8'ha0, 8'hb0, 8'h88, 8'h88, 8'h80};
  logic [7:0] row_d [5] = '{8'h01, 8'h01, 8'h55, 8'h55, 8'h3c};
  logic [1:0] row_st [5] = '{2'h3, 2'h3, 2'h1, 2'h2, 2'h3};
  logic [3:0] row_fl [5] = '{4'h8, 4'h0, 4'h2, 4'h2, 4'h4};
  // Transmit rows: ctrl2, empty, idle, expected request
  logic [10:0] tx_row [4] = '{{8'h80, 3'b101}, {8'h40, 3'b100}, {8'h40, 3'b011}, {8'h20, 3'b110}};

  uart_rx_error_irq_wake uart_rx_error_irq_wake_inst (.clk_sys(clk_sys), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .serial_pin(serial_pin), .port_clk_on(port_clk_on),
    .tx_empty_flag(tx_empty_flag), .tx_idle_flag(tx_idle_flag), .tx_load(tx_load),
    .tx_data(tx_data), .global_irq_enable(1'b1), .group_irq_enable(group_irq_enable),
    .channel_irq_enable(1'b1), .irq_req(irq_req), .irq_pulse_b(irq_pulse_b),
    .wake_req(wake_req));
  serial_source serial_source_inst (.clk_sys(clk_sys), .serial_pin(serial_pin));

  // 25 MHz clock
  always #20 clk_sys = ~clk_sys;

  // Run-length guard
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc > 60000) begin
      error_cnt++;
      $display("Error run_length expected %0d seen %0d", 60000, cyc);
      complete_run();
    end
  end

  // Register port cycles
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    d = reg_rdata;
  endtask : rd
  task automatic chk(input string name, input logic [8:0] exp, input logic [8:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic complete_run;
    $display("Checks %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : complete_run

  // Main sequence
  initial begin
    repeat (10) @(posedge clk_sys);
    rst_b <= 1'b1;
    wr(`OFS_BAUD, 8'h00);
    wr(`OFS_CTRL1, 8'h80);
    wr(`OFS_CTRL2, 8'h30);
    wr(`OFS_STATUS, 8'hff);
    rd(`OFS_STATUS, rv);
    chk("status_ro", 9'h008, {1'b0, rv});
    rd(3'h5, rv);
    chk("unmapped", 9'h000, {1'b0, rv});
    wr(`OFS_DATA, 8'h5a);
    rd(`OFS_DATA, rv);
    chk("empty_data", 9'h000, {1'b0, rv});
    for (int k = 0; k < 3; k++) serial_source_inst.send(9'(9'h41 + k), 8, 1'b0, 1'b0, 1, 2'h3, 1'b0);
    @(negedge clk_sys);
    chk("irq_rx", 9'h001, {8'h00, irq_req});
    rd(`OFS_DATA, rv);
    chk("first_word", 9'h041, {1'b0, rv});
    rd(`OFS_STATUS, rv);
    chk("overrun_kept", 9'h01c, {1'b0, rv});
    rd(`OFS_DATA, rv);
    chk("second_word", 9'h042, {1'b0, rv});
    rd(`OFS_STATUS, rv);
    chk("overrun_clear", 9'h008, {1'b0, rv});
    for (int i = 0; i < 5; i++) begin
      wr(`OFS_CTRL1, row_c1[i]);
      serial_source_inst.send({1'b0, row_d[i]}, 8, row_c1[i][5], 1'b0,
                              row_c1[i][3] ? 2 : 1, row_st[i], i == 4);
      rd(`OFS_STATUS, rv);
      chk("error_flags", {1'b0, row_fl[i], 4'hc}, {1'b0, rv});
      rd(`OFS_DATA, rv);
      chk("error_data", {1'b0, row_d[i]}, {1'b0, rv});
    end
    wr(`OFS_CTRL2, 8'h38);
    for (int i = 0; i < 4; i++) begin
      w = i[1] ? {i[0], 8'h05} : {1'b0, i[0], 7'h05};
      wr(`OFS_CTRL1, i[1] ? 8'hc0 : 8'h80);
      serial_source_inst.send(w, i[1] ? 9 : 8, 1'b0, 1'b0, 1, 2'h3, 1'b0);
      @(negedge clk_sys);
      chk("addr_irq", {8'h00, i[0]}, {8'h00, irq_req});
      rd(`OFS_CTRL1, rv);
      chk("rx_bit8", {1'b0, 1'b1, i[1], 5'h00, w[8]}, {1'b0, rv});
      rd(`OFS_DATA, rv);
      chk("addr_data", {1'b0, w[7:0]}, {1'b0, rv});
    end
    for (int j = 0; j < 4; j++) begin
      @(posedge clk_sys);
      tx_empty_flag <= tx_row[j][2];
      tx_idle_flag <= tx_row[j][1];
      wr(`OFS_CTRL2, tx_row[j][10:3]);
      @(negedge clk_sys);
      chk("tx_irq", {8'h00, tx_row[j][0]}, {8'h00, irq_req});
    end
    @(posedge clk_sys);
    tx_empty_flag <= 1'b0;
    tx_idle_flag <= 1'b0;
    wr(`OFS_CTRL1, 8'h80);
    wr(`OFS_CTRL2, 8'h34);
    for (int w2 = 0; w2 < 2; w2++) begin
      @(posedge clk_sys);
      group_irq_enable <= (w2 == 0);
      port_clk_on <= 1'b0;
      serial_source_inst.drive(1'b0);
      n = 0;
      while (wake_req !== 1'b1 && n < 20) begin
        @(negedge clk_sys);
        n++;
      end
      chk("wake_req", 9'h001, {8'h00, wake_req});
      serial_source_inst.drive(1'b1);
      rd(`OFS_CTRL2, rv);
      chk("ctrl2_sleep", 9'h034, {1'b0, rv});
      @(posedge clk_sys);
      port_clk_on <= 1'b1;
      n = -1;
      for (int c = 0; c < 40; c++) begin
        serial_source_inst.drive(c < 2 || c > 21);
        @(negedge clk_sys);
        if (irq_req === 1'b1 && n < 0) n = c;
      end
      chk("wake_irq", 9'h001, {8'h00, w2 == 0 ? (n >= 13 && n <= 17) : (n < 0)});
      repeat (200) @(negedge clk_sys);
      rd(`OFS_STATUS, rv);
      chk("wake_ignored", 9'h008, {1'b0, rv});
    end
    complete_run();
  end
endmodule : uart_rx_error_irq_wake_bench
`default_nettype wire
